// File: pkg/freq_lock_defines.svh
// Purpose: offsets, field positions, reset values, timing counts
// Assumes: one word per register on a 32-bit AXI4-Lite bus
// Notes:   frequencies in 0.01 Hz, times in 0.1 s, offset = index*4
`ifndef FREQ_LOCK_DEFINES_SVH
`define FREQ_LOCK_DEFINES_SVH
`define IX_PWD_ENTRY 5'd0
`define IX_RATED_I   5'd1
`define IX_RATED_P   5'd2
`define IX_EDITION   5'd3
`define IX_CTRL_MODE 5'd4
`define IX_PWD_EN    5'd5
`define IX_PWD       5'd6
`define IX_START_F   5'd7
`define IX_HOLD_T    5'd8
`define IX_MAX_F     5'd9
`define IX_MIN_F     5'd10
`define IX_TGT_F     5'd11
`define IX_RAMP0     5'd12
`define IX_RAMP_REF  5'd20
`define IX_AO_CODE   5'd21
`define IX_STATUS    5'd22
`define IX_OUT_F     5'd23
`define IX_IRQ_ST    5'd24
`define IX_IRQ_MSK   5'd25
`define RST_CTRL_MODE 16'h0002
`define RST_PWD       16'h0008
`define RST_MAX_F     16'h1388
`define RST_MIN_F     16'h0032
`define RST_TGT_F     16'h1388
`define RST_RAMP_T    16'h0064
`define PWD_MAX       16'h270F
`define START_F_MAX   16'h03E8
`define HOLD_T_MAX    16'h270F
`define MAX_F_LIMIT   16'hE678
`define RAMP_T_MAX    16'h7530
`define SPAN_50HZ     16'h1388
`define IRQ_LOCK_ERR  0
`define IRQ_BAD_VAL   1
`define IRQ_REACHED   2
`define CLK_MHZ       125
`define TICK_US       1
`define TICK_CYC      (`TICK_US * `CLK_MHZ)
`define US_PER_DSEC   100000
`endif

// File: pkg/freq_lock_pkg.sv
// Purpose: types shared by the setpoint and lock logic
// Assumes: nothing
// Notes:   none
package freq_lock_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_HOLD  = 3'b001,
        ST_RUN   = 3'b010,
        ST_TRACK = 3'b011,
        ST_STOP  = 3'b100
    } run_state_t;
    typedef enum logic [2:0] {
        MODE_SVC     = 3'b000,
        MODE_RSVD    = 3'b001,
        MODE_VF      = 3'b010,
        MODE_VEC1    = 3'b011,
        MODE_PM_SVC  = 3'b110
    } ctrl_mode_t;
    typedef enum logic [2:0] {
        AO_0_5V   = 3'b000,
        AO_0_10V  = 3'b001,
        AO_0_20MA = 3'b010,
        AO_4_20MA = 3'b011,
        AO_RSVD   = 3'b111
    } ao_range_t;
endpackage

// File: verilog/drive_frequency_setpoint_lock.sv
// Purpose: parameter lock, setpoint planning and ramp of an inverter
// Assumes: pins are asynchronous to i_clk; AXI4-Lite master is compliant
// Notes:   output frequency in 0.01 Hz units
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`include "freq_lock_defines.svh"

module drive_frequency_setpoint_lock
    import freq_lock_pkg::*;
#(
    parameter int          TICK_CYC  = `TICK_CYC,
    parameter logic [15:0] RATED_I   = 16'h0000,
    parameter logic [15:0] RATED_P   = 16'h0000,
    // arbitrary value, 1.00
    parameter logic [15:0] EDITION   = 16'h0064
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    // axi4-lite slave
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    // pins
    input  wire logic        i_run,
    input  wire logic        i_fault_reset,
    input  wire logic        i_fly_start,
    input  wire logic        i_track_done,
    input  wire logic [15:0] i_track_freq,
    input  wire logic [1:0]  i_ramp_sel,
    input  wire logic        i_jumper_current,
    // outputs
    output logic [15:0]      o_freq,
    output ctrl_mode_t       o_ctrl_mode,
    output ao_range_t        o_ao_range,
    output logic             o_irq
);
    // ******************************
    // input synchronisers
    // ******************************
    logic [22:0] s1_q, s2_q;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= {i_run, i_fault_reset, i_fly_start, i_track_done,
                     i_track_freq, i_ramp_sel, i_jumper_current};
            s2_q <= s1_q;
        end
    end
    wire        run_s  = s2_q[22];
    wire        frst_s = s2_q[21];
    wire        fly_s  = s2_q[20];
    wire        tdon_s = s2_q[19];
    wire [15:0] trk_s  = s2_q[18:3];
    wire [1:0]  rsel_s = s2_q[2:1];
    wire        jcur_s = s2_q[0];

    // ******************************
    // parameter store and checks
    // ******************************
    logic [15:0] prm_q [4:21];
    logic        locked_q, run_d_q;
    logic [2:0]  irq_st_q, irq_msk_q;
    wire  prot = prm_q[`IX_PWD_EN][0] && locked_q;

    function automatic logic [15:0] rst_val(input logic [4:0] ix);
        if (ix == `IX_CTRL_MODE) rst_val = `RST_CTRL_MODE;
        else if (ix == `IX_PWD) rst_val = `RST_PWD;
        else if (ix == `IX_MAX_F) rst_val = `RST_MAX_F;
        else if (ix == `IX_MIN_F) rst_val = `RST_MIN_F;
        else if (ix == `IX_TGT_F) rst_val = `RST_TGT_F;
        else if (ix >= `IX_RAMP0 && ix < `IX_RAMP_REF)
            rst_val = `RST_RAMP_T;
        else rst_val = 16'h0000;
    endfunction

    // value within its settable range, judged against live neighbours
    function automatic logic val_ok(input logic [4:0] ix,
                                    input logic [31:0] v);
        logic [15:0] w;
        w = v[15:0];
        if (v[31:16] != 16'h0000) val_ok = 1'b0;
        else if (ix == `IX_CTRL_MODE)
            val_ok = w == 16'h0000 || w == 16'h0002 ||
                     w == 16'h0003 || w == 16'h0006;
        else if (ix == `IX_PWD_EN || ix == `IX_RAMP_REF)
            val_ok = w <= 16'h0001;
        else if (ix == `IX_PWD || ix == `IX_PWD_ENTRY)
            val_ok = w <= `PWD_MAX;
        else if (ix == `IX_START_F)
            val_ok = w <= `START_F_MAX && w < prm_q[`IX_MAX_F];
        else if (ix == `IX_HOLD_T) val_ok = w <= `HOLD_T_MAX;
        else if (ix == `IX_MAX_F)
            val_ok = w >= prm_q[`IX_TGT_F] && w <= `MAX_F_LIMIT;
        else if (ix == `IX_MIN_F)
            val_ok = w <= prm_q[`IX_TGT_F];
        else if (ix == `IX_TGT_F)
            val_ok = w >= prm_q[`IX_MIN_F] && w <= prm_q[`IX_MAX_F];
        else if (ix >= `IX_RAMP0 && ix < `IX_RAMP_REF)
            val_ok = w != 16'h0000 && w <= `RAMP_T_MAX;
        else if (ix == `IX_AO_CODE) val_ok = w <= 16'h0002;
        else val_ok = 1'b1;
    endfunction

    // ******************************
    // axi4-lite write path
    // ******************************
    wire       wr_go  = i_awvalid && i_wvalid && !o_bvalid;
    wire [4:0] wix    = i_awaddr[6:2];
    wire       w_ro   = wix >= `IX_RATED_I && wix <= `IX_EDITION;
    wire       w_prm  = wix >= `IX_CTRL_MODE && wix <= `IX_AO_CODE;
    wire       w_irq  = wix == `IX_IRQ_ST || wix == `IX_IRQ_MSK;
    wire       w_map  = i_awaddr[7] == 1'b0 &&
                        (wix == `IX_PWD_ENTRY || w_ro || w_prm || w_irq);
    wire       w_full = i_wstrb == 4'hF;
    // a locked device still takes the password entry itself
    wire w_lock = prot && w_prm;
    wire w_bad  = (w_prm || wix == `IX_PWD_ENTRY) && !val_ok(wix, i_wdata);
    wire w_do   = wr_go && w_map && w_full && !w_ro && !w_lock && !w_bad;
    assign o_awready = wr_go;
    assign o_wready  = wr_go;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_bvalid <= 1'b0;
            o_bresp  <= 2'b00;
        end else if (wr_go) begin
            o_bvalid <= 1'b1;
            if (!w_map) o_bresp <= 2'b11;
            else if (w_do || (w_irq && w_full)) o_bresp <= 2'b00;
            else o_bresp <= 2'b10;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 4; i <= 21; i++) prm_q[i] <= rst_val(5'(i));
        end else if (w_do && w_prm) begin
            prm_q[wix] <= i_wdata[15:0];
        end
    end

    // relocks on reset and on every fault reset
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) locked_q <= 1'b1;
        else if (frst_s) locked_q <= 1'b1;
        else if (w_do && wix == `IX_PWD_ENTRY &&
                 i_wdata[15:0] == prm_q[`IX_PWD])
            locked_q <= 1'b0;
    end

    // ******************************
    // axi4-lite read path
    // ******************************
    logic [4:0]  rix;
    logic [31:0] rd_v;
    logic        rd_ok;
    logic [15:0] freq_q;
    run_state_t  st_q;
    assign o_arready = !o_rvalid;
    always_comb begin
        rix   = i_araddr[6:2];
        rd_ok = i_araddr[7] == 1'b0 && rix <= `IX_IRQ_MSK;
        rd_v  = 32'h0000_0000;
        if (rix == `IX_RATED_I) rd_v[15:0] = RATED_I;
        else if (rix == `IX_RATED_P) rd_v[15:0] = RATED_P;
        else if (rix == `IX_EDITION) rd_v[15:0] = EDITION;
        else if (rix == `IX_PWD && prot) rd_v = 32'h0000_0000;
        else if (rix >= `IX_CTRL_MODE && rix <= `IX_AO_CODE)
            rd_v[15:0] = prm_q[rix];
        else if (rix == `IX_STATUS)
            rd_v[4:0] = {st_q, prot, locked_q};
        else if (rix == `IX_OUT_F) rd_v[15:0] = freq_q;
        else if (rix == `IX_IRQ_ST) rd_v[2:0] = irq_st_q;
        else if (rix == `IX_IRQ_MSK) rd_v[2:0] = irq_msk_q;
    end
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h0000_0000;
            o_rresp  <= 2'b00;
        end else if (i_arvalid && !o_rvalid) begin
            o_rvalid <= 1'b1;
            o_rdata  <= rd_v;
            o_rresp  <= rd_ok ? 2'b00 : 2'b11;
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    // ******************************
    // frequency planning
    // ******************************
    logic [$clog2(TICK_CYC+1)-1:0] tick_cnt_q;
    logic        tick;
    logic [31:0] hold_q, acc_q;
    logic [15:0] set_f, span, rt;
    logic [32:0] acc_nx, denom;
    assign tick = tick_cnt_q == '0;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) tick_cnt_q <= '0;
        else if (tick) tick_cnt_q <= ($bits(tick_cnt_q))'(TICK_CYC - 1);
        else tick_cnt_q <= tick_cnt_q - 1'b1;
    end

    wire [15:0] mn = prm_q[`IX_MIN_F];
    wire [15:0] mx = prm_q[`IX_MAX_F];
    wire [15:0] sf = prm_q[`IX_START_F];
    wire        up = freq_q < set_f;
    always_comb begin
        if (st_q == ST_STOP) set_f = 16'h0000;
        else if (prm_q[`IX_TGT_F] < mn) set_f = mn;
        else if (prm_q[`IX_TGT_F] > mx) set_f = mx;
        else set_f = prm_q[`IX_TGT_F];
        span = prm_q[`IX_RAMP_REF][0] ? mx : `SPAN_50HZ;
        rt = prm_q[5'(`IX_RAMP0 + {rsel_s, !up})];
        denom = 33'(rt) * 33'(`US_PER_DSEC);
        acc_nx = 33'(acc_q) + 33'(span);
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q   <= ST_IDLE;
            freq_q <= 16'h0000;
            hold_q <= 32'h0000_0000;
            acc_q  <= 32'h0000_0000;
        end else begin
            case (st_q)
            ST_IDLE: begin
                acc_q <= 32'h0000_0000;
                if (run_s && !run_d_q) begin
                    if (fly_s) st_q <= ST_TRACK;
                    else if (prm_q[`IX_TGT_F] >= sf) begin
                        st_q   <= ST_HOLD;
                        freq_q <= sf;
                        hold_q <= 32'(prm_q[`IX_HOLD_T]) *
                                  32'(`US_PER_DSEC);
                    end else st_q <= ST_RUN;
                end
            end
            ST_HOLD: begin
                if (!run_s) st_q <= ST_STOP;
                else if (hold_q == 32'h0000_0000) begin
                    st_q <= ST_RUN;
                    freq_q <= freq_q < mn ? mn :
                              (freq_q > mx ? mx : freq_q);
                end else if (tick) hold_q <= hold_q - 1'b1;
            end
            ST_TRACK: begin
                freq_q <= trk_s;
                if (!run_s) st_q <= ST_STOP;
                else if (tdon_s) st_q <= ST_RUN;
            end
            ST_RUN, ST_STOP: begin
                if (st_q == ST_RUN && !run_s) st_q <= ST_STOP;
                if (st_q == ST_STOP && freq_q == 16'h0000)
                    st_q <= ST_IDLE;
                if (st_q == ST_RUN && freq_q < mn) freq_q <= mn;
                else if (st_q == ST_RUN && freq_q > mx) freq_q <= mx;
                else if (freq_q == set_f) acc_q <= 32'h0000_0000;
                else if (tick) begin
                    if (acc_nx >= denom) begin
                        acc_q  <= 32'(acc_nx - denom);
                        freq_q <= up ? freq_q + 1'b1 : freq_q - 1'b1;
                    end else acc_q <= acc_nx[31:0];
                end
            end
            default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ******************************
    // events, decodes, outputs
    // ******************************
    wire reached = st_q == ST_RUN && freq_q == set_f && tick;
    wire [2:0] ev = {reached, wr_go && w_map && w_bad && !w_lock,
                     wr_go && w_lock};
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_st_q  <= 3'b000;
            irq_msk_q <= 3'b000;
            run_d_q   <= 1'b0;
        end else begin
            run_d_q <= run_s;
            // a new event wins over a clearing write
            if (wr_go && w_full && wix == `IX_IRQ_ST)
                irq_st_q <= (irq_st_q & ~i_wdata[2:0]) | ev;
            else irq_st_q <= irq_st_q | ev;
            if (wr_go && w_full && wix == `IX_IRQ_MSK)
                irq_msk_q <= i_wdata[2:0];
        end
    end
    assign o_irq  = |(irq_st_q & irq_msk_q);
    assign o_freq = freq_q;
    assign o_ctrl_mode = ctrl_mode_t'(prm_q[`IX_CTRL_MODE][2:0]);
    always_comb begin
        case ({jcur_s, prm_q[`IX_AO_CODE][1:0]})
            3'b000:  o_ao_range = AO_0_5V;
            3'b001:  o_ao_range = AO_0_10V;
            3'b101:  o_ao_range = AO_0_20MA;
            3'b110:  o_ao_range = AO_4_20MA;
            default: o_ao_range = AO_RSVD;
        endcase
    end

    // ******************************
    // assertions
    // ******************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    AST_LOCK_REFUSE: assert property (wr_go && w_lock |=>
        o_bresp == 2'b10 && irq_st_q[`IRQ_LOCK_ERR] && $stable(prm_q[wix]))
        else $error("locked write not refused");
    AST_OPEN_WRITE: assert property (wr_go && !prot && w_prm &&
        w_full && val_ok(wix, i_wdata) |=> o_bresp == 2'b00)
        else $error("unprotected write refused");
    AST_UNLOCK: assert property (w_do && wix == `IX_PWD_ENTRY &&
        i_wdata[15:0] == prm_q[`IX_PWD] && !frst_s |=> !locked_q)
        else $error("matching password did not unlock");
    AST_PWD_HIDDEN: assert property (i_arvalid && !o_rvalid &&
        rix == `IX_PWD && prot |=> o_rdata == 32'h0000_0000)
        else $error("password visible while locked");
    AST_READ_ONLY: assert property (wr_go && w_ro |=>
        o_bresp == 2'b10)
        else $error("read-only write accepted");
    AST_MODE_LEGAL: assert property (o_ctrl_mode != MODE_RSVD)
        else $error("reserved control mode stored");
    AST_HOLD_START: assert property (st_q == ST_HOLD |->
        freq_q == sf || !$stable(sf))
        else $error("hold frequency differs from start");
    AST_RUN_LIMITS: assert property (st_q == ST_RUN &&
        $past(st_q) == ST_RUN && $stable(mn) && $stable(mx) &&
        $past(mn) <= $past(mx) |-> freq_q >= mn && freq_q <= mx)
        else $error("running frequency outside limits");
    AST_TRACK_FOLLOW: assert property (st_q == ST_TRACK &&
        run_s && !tdon_s |=> freq_q == $past(trk_s))
        else $error("tracking does not follow motor");
    AST_RAMP_STEP: assert property (st_q == ST_RUN &&
        $past(st_q) == ST_RUN && freq_q >= mn && freq_q <= mx |=>
        freq_q - $past(freq_q) <= 16'h0001 ||
        $past(freq_q) - freq_q <= 16'h0001)
        else $error("ramp jumped");
    COV_LOCK: cover property (wr_go && w_lock);
    COV_HOLD_RUN: cover property (st_q == ST_HOLD ##1 st_q == ST_RUN);
    COV_TRACK: cover property (st_q == ST_TRACK ##1 st_q == ST_RUN);
endmodule

// File: verification/operator_host.sv
// Purpose: operator side model, an AXI4-Lite master for parameters
// Assumes: tasks are entered just after a rising clock edge
// Notes:   o_hung rises when a handshake does not complete in time
module operator_host (
    // answers from the block
    input  wire logic        i_clk,
    input  wire logic        i_awready, i_wready, i_bvalid, i_arready,
    input  wire logic        i_rvalid,
    input  wire logic [1:0]  i_bresp, i_rresp,
    input  wire logic [31:0] i_rdata,
    // requests to the block
    output logic [7:0]       o_awaddr, o_araddr,
    output logic [31:0]      o_wdata,
    output logic [3:0]       o_wstrb,
    output logic             o_awvalid, o_wvalid, o_bready,
    output logic             o_arvalid, o_rready, o_hung
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {o_awaddr, o_araddr, o_wdata, o_wstrb} = '0;
        {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = '0;
        o_hung = 1'b0;
    end

    // waits for one handshake: 0 aw and w, 1 b, 2 ar, 3 r
    task automatic till(input int s, inout int n);
        logic [3:0] h;
        do begin
            @(posedge i_clk);
            n++;
            h = {i_rvalid, i_arready, i_bvalid, i_awready && i_wready};
        end while (h[s] !== 1'b1 && n < 200);
        o_hung <= (n >= 200);
    endtask

    // unlocking is an ordinary write of the entry word
    task automatic wr(input logic [4:0] ix, input logic [15:0] v,
                      output logic [1:0] resp);
        int n;
        n = 0;
        o_awaddr  <= {1'b0, ix, 2'b00};
        o_wdata   <= {16'h0000, v};
        o_wstrb   <= 4'hF;
        o_awvalid <= 1'b1;
        o_wvalid  <= 1'b1;
        o_bready  <= 1'b1;
        till(0, n);
        o_awvalid <= 1'b0;
        o_wvalid  <= 1'b0;
        till(1, n);
        resp = i_bresp;
        o_bready <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic rd(input logic [4:0] ix, output logic [31:0] d,
                      output logic [1:0] resp);
        int n;
        n = 0;
        o_araddr  <= {1'b0, ix, 2'b00};
        o_arvalid <= 1'b1;
        o_rready  <= 1'b1;
        till(2, n);
        o_arvalid <= 1'b0;
        till(3, n);
        d    = i_rdata;
        resp = i_rresp;
        o_rready <= 1'b0;
        @(posedge i_clk);
    endtask
endmodule

// File: verification/drive_frequency_setpoint_lock_tb.sv
// Purpose: self-checking bench for the setpoint and parameter lock
// Assumes: operator_host drives the register bus
// Notes:   TK shortens the 1 us tick so that ramps end quickly
`include "freq_lock_defines.svh"
module drive_frequency_setpoint_lock_tb
    import freq_lock_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int          TK = 2;
    localparam logic [15:0] RI = 16'h0010;
    localparam logic [15:0] ED = 16'h00C8;  // arbitrary edition value
    logic        i_clk = 1'b0, i_nrst = 1'b0, hung;
    logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
    logic [7:0]  i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata;
    logic [3:0]  i_wstrb;
    logic [1:0]  o_bresp, o_rresp, i_ramp_sel = 2'b00;
    logic        i_run = 1'b0, i_fault_reset = 1'b0, i_fly_start = 1'b0;
    logic        i_track_done = 1'b0, i_jumper_current = 1'b0;
    logic [15:0] i_track_freq = 16'h0000, o_freq;
    ctrl_mode_t  o_ctrl_mode;
    ao_range_t   o_ao_range;
    int          mismatches = 0, samples_checked = 0;

    operator_host host (
        .i_clk, .i_awready(o_awready), .i_wready(o_wready),
        .i_bvalid(o_bvalid),
        .i_arready(o_arready), .i_rvalid(o_rvalid), .i_bresp(o_bresp),
        .i_rresp(o_rresp), .i_rdata(o_rdata), .o_awaddr(i_awaddr),
        .o_araddr(i_araddr), .o_wdata(i_wdata), .o_wstrb(i_wstrb),
        .o_awvalid(i_awvalid), .o_wvalid(i_wvalid), .o_bready(i_bready),
        .o_arvalid(i_arvalid), .o_rready(i_rready), .o_hung(hung));
    drive_frequency_setpoint_lock #(.TICK_CYC(TK), .RATED_I(RI),
        .RATED_P(16'h0020), .EDITION(ED)) uut (
        .i_clk, .i_nrst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
        .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
        .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
        .i_rready, .i_run, .i_fault_reset, .i_fly_start, .i_track_done,
        .i_track_freq, .i_ramp_sel, .i_jumper_current, .o_freq,
        .o_ctrl_mode, .o_ao_range, .o_irq);

    always #4 i_clk = ~i_clk;
    always @(posedge hung) begin
        mismatches++;
        end_of_test();
    end

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wc(input logic [4:0] ix, input logic [15:0] v,
                      input logic [1:0] er);
        logic [1:0] r;
        host.wr(ix, v, r);
        check(r, er);
    endtask
    task automatic rc(input logic [4:0] ix, input logic [15:0] ev);
        logic [31:0] d;
        logic [1:0]  r;
        host.rd(ix, d, r);
        check(d, {16'h0000, ev});
        check(r, 2'b00);
    endtask
    task automatic first_nz(input logic [15:0] f);
        int n;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_freq === 16'h0000 && n < 100);
        check(o_freq, f);
        if (n >= 100) end_of_test();
    endtask
    // a wait that runs out ends the run after its failed compare
    task automatic wait_freq(input logic [15:0] f);
        int n;
        n = 0;
        while (o_freq !== f && n < 20000) begin
            @(posedge i_clk);
            n++;
        end
        check(o_freq, f);
        if (n >= 20000) end_of_test();
    endtask
    task automatic stop_run();
        i_run <= 1'b0;
        wait_freq(16'h0000);
        repeat (4) @(posedge i_clk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        check(o_ctrl_mode, MODE_VF);
        rc(`IX_PWD, 16'h0008);
        rc(`IX_STATUS, 16'h0001);
        rc(`IX_MAX_F, 16'h1388);
        rc(`IX_MIN_F, 16'h0032);
        rc(`IX_TGT_F, 16'h1388);
        rc(`IX_EDITION, ED);
        wc(`IX_RATED_I, 16'h0001, 2'b10);
        rc(`IX_RATED_I, RI);
        wc(5'd26, 16'h0000, 2'b11);
        $display("done reset and read-only");
    endtask
    task automatic t_modes();
        ctrl_mode_t md[4] = '{MODE_SVC, MODE_VF, MODE_VEC1, MODE_PM_SVC};
        for (int k = 0; k < 4; k++) begin
            wc(`IX_CTRL_MODE, {13'h0000, md[k]}, 2'b00);
            check(o_ctrl_mode, md[k]);
        end
        wc(`IX_CTRL_MODE, 16'h0001, 2'b10);
        check(o_ctrl_mode, MODE_PM_SVC);
        $display("done control modes");
    endtask
    task automatic t_lock();
        logic [1:0] r;
        wc(`IX_PWD_EN, 16'h0001, 2'b00);
        wc(`IX_CTRL_MODE, 16'h0003, 2'b10);
        rc(`IX_PWD, 16'h0000);
        wc(`IX_IRQ_MSK, 16'h0001, 2'b00);
        check(o_irq, 1'b1);
        wc(`IX_IRQ_ST, 16'h0001, 2'b00);
        check(o_irq, 1'b0);
        host.wr(`IX_PWD_ENTRY, 16'h0007, r);
        wc(`IX_CTRL_MODE, 16'h0003, 2'b10);
        wc(`IX_PWD_ENTRY, 16'h0008, 2'b00);
        wc(`IX_CTRL_MODE, 16'h0003, 2'b00);
        rc(`IX_PWD, 16'h0008);
        i_fault_reset <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_fault_reset <= 1'b0;
        repeat (4) @(posedge i_clk);
        wc(`IX_CTRL_MODE, 16'h0002, 2'b10);
        host.wr(`IX_PWD_ENTRY, 16'h0008, r);
        wc(`IX_PWD_EN, 16'h0000, 2'b00);
        wc(`IX_IRQ_MSK, 16'h0000, 2'b00);
        wc(`IX_CTRL_MODE, 16'h0002, 2'b00);
        $display("done password lock");
    endtask
    task automatic t_ao();
        ao_range_t ev[6] = '{AO_0_5V, AO_0_10V, AO_RSVD,
                             AO_RSVD, AO_0_20MA, AO_4_20MA};
        for (int k = 0; k < 6; k++) begin
            i_jumper_current <= (k > 2);
            wc(`IX_AO_CODE, 16'(k % 3), 2'b00);
            repeat (4) @(posedge i_clk);
            check(o_ao_range, ev[k]);
        end
        $display("done output range");
    endtask
    task automatic t_cfg();
        wc(`IX_TGT_F, 16'h0064, 2'b00);
        wc(`IX_MIN_F, 16'h0000, 2'b00);
        wc(`IX_START_F, 16'h0032, 2'b00);
        wc(`IX_HOLD_T, 16'h0000, 2'b00);
        for (int k = 0; k < 8; k++)
            wc(5'(k + 12), (k == 4) ? 16'h0002 : 16'h0001, 2'b00);
        $display("done setup");
    endtask
    task automatic t_ramp(input logic [1:0] sel, input logic [15:0] rf,
                          input logic [15:0] mx, input int gap);
        int n;
        wc(`IX_MAX_F, mx, 2'b00);
        wc(`IX_RAMP_REF, rf, 2'b00);
        i_ramp_sel <= sel;
        i_run      <= 1'b1;
        first_nz(16'h0032);
        wait_freq(16'h0050);
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_freq !== 16'h0051 && n < 1000);
        check(n, gap);
        if (n >= 1000) end_of_test();
        wait_freq(16'h0064);
        stop_run();
        $display("done ramp case");
    endtask
    task automatic t_min();
        wc(`IX_MIN_F, 16'h0065, 2'b10);
        wc(`IX_MAX_F, 16'hE679, 2'b10);
        wc(`IX_MAX_F, 16'hE678, 2'b00);
        wc(`IX_MIN_F, 16'h003C, 2'b00);
        rc(`IX_IRQ_ST, 16'h0007);
        i_run <= 1'b1;
        first_nz(16'h0032);
        @(posedge i_clk);
        check(o_freq, 16'h003C);
        wait_freq(16'h0064);
        stop_run();
        wc(`IX_START_F, 16'h012C, 2'b00);
        i_run <= 1'b1;
        first_nz(16'h003C);
        wait_freq(16'h0064);
        stop_run();
        $display("done minimum clamp");
    endtask
    task automatic t_fly();
        i_fly_start  <= 1'b1;
        i_track_freq <= 16'h0014;
        i_run        <= 1'b1;
        first_nz(16'h0014);
        repeat (20) @(posedge i_clk);
        check(o_freq, 16'h0014);
        i_track_done <= 1'b1;
        wait_freq(16'h0064);
        i_fly_start  <= 1'b0;
        stop_run();
        $display("done flying start");
    endtask

    initial begin
        repeat (6) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        t_reset();
        t_modes();
        t_lock();
        t_ao();
        t_cfg();
        t_ramp(2'd0, 16'h0000, 16'h1388, 20 * TK);
        t_ramp(2'd2, 16'h0000, 16'h1388, 40 * TK);
        t_ramp(2'd0, 16'h0001, 16'h2710, 10 * TK);
        t_min();
        t_fly();
        end_of_test();
    end
endmodule
